// File: rtc_calendar_stopwatch_control.sv
// calendar clock counters, control bits and stopwatch behind an axi4-lite slave
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps

// What this block does
// - hold bit freezes time count-up; clearing resumes at once
// - hold cannot be set while regulation busy; stays 0
// - format bit picks 24h or 12h range; stored hour untouched
// - adjust bit starts 30 s correction, reads 1, self-clears within 2/256 s
// - soft reset clears divider, adjust and hold; reads 1 then clears
// - run bit starts and stops counting, value kept across stops
// - trim write sets regulation busy, clears by itself within 1 s
// - trim reads 0, writes while busy ignored, zero trim corrects nothing
// - second alarm: tens in 14-12, units in 11-8, bcd 0-59
// - alarm pm bit matters in 12h mode only
// - alarm hour bcd 1-12 or 0-23; alarm minute bcd 0-59
// - stopwatch digits are read-only bcd; software reads twice
// - stopwatch clear zeroes count, running keeps counting, reads 0
// - stopwatch run starts/stops at next stopwatch clock, count kept
// - second counter read/write as bcd tens and units, 0-59
// - low byte of second register shows divider stages, reset clears
// - divider bits may tear while running; software reads twice
// - pm bit reads 0 in 24h, ignores 1, clears at next hour step
// - hour bcd 1-12 or 0-23; minute bcd 0-59
// - counter busy for 1/256 s on count-up or corrections
// - 30 s correction: 30-59 clears seconds and adds a minute
// - count-ups missed during hold give exactly one extra second
module rtc_calendar_stopwatch_control
    import rtc_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES
)(
    input logic clk,
    input logic rst,
    input logic [7:0] awaddr,
    input logic [2:0] awprot,
    input logic awvalid,
    output logic awready,
    input logic [31:0] wdata,
    input logic [3:0] wstrb,
    input logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input logic bready,
    input logic [7:0] araddr,
    input logic [2:0] arprot,
    input logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input logic rready,
    output logic alarm_match,
    output logic adjust_done
);

    localparam logic [PRESC_W-1:0] TICK_LAST = PRESC_W'(TICK_DIV - 1);

    st_t q, d;
    logic tick;
    logic sec_evt;
    logic wr_go;
    logic ar_hs;
    logic [15:0] m;
    logic [8:0] acc;

    // ----------------------------------------------------------------
    // bcd arithmetic
    // ----------------------------------------------------------------
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        return (v[3:0] >= 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic bcd_bad(input logic [7:0] v, input logic [7:0] top);
        return (v[3:0] > 4'h9) || (v > top);
    endfunction

    // one second step with carries; out-of-range values restart the field
    function automatic time_t step_sec(input time_t t, input logic f24);
        time_t r;
        logic [7:0] h;
        logic [7:0] hn;
        logic [7:0] mn;
        logic [7:0] sn;
        r = t;
        h = {2'h0, t.hour};
        hn = bcd_inc(h);
        mn = bcd_inc({1'b0, t.min});
        sn = bcd_inc({1'b0, t.sec});
        if (t.sec == 7'h59 || bcd_bad({1'b0, t.sec}, 8'h59))
        begin
            r.sec = 7'h00;
            if (t.min == 7'h59 || bcd_bad({1'b0, t.min}, 8'h59))
            begin
                r.min = 7'h00;
                if (f24)
                begin
                    r.pm = 1'b0;
                    r.hour = (h >= 8'h23 || bcd_bad(h, 8'h23)) ? 6'h00 : hn[5:0];
                end
                else if (h == 8'h12 || h == 8'h00 || bcd_bad(h, 8'h12))
                    r.hour = 6'h01;
                else
                begin
                    r.hour = hn[5:0];
                    if (h == 8'h11)
                        r.pm = ~t.pm;
                end
            end
            else
                r.min = mn[6:0];
        end
        else
            r.sec = sn[6:0];
        return r;
    endfunction

    function automatic logic [15:0] lane_mask(input logic [1:0] s);
        return {{8{s[1]}}, {8{s[0]}}};
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return a == CTL_LOW_OFS || a == CTL_HIGH_OFS || a == ALARM_SEC_OFS
            || a == ALARM_HM_OFS || a == SW_CTL_OFS || a == SEC_DIV_OFS || a == HOUR_MIN_OFS;
    endfunction

    // ----------------------------------------------------------------
    // bus handshakes
    // ----------------------------------------------------------------
    assign awready = !q.aw_ok && !q.bvalid;
    assign wready = !q.w_ok && !q.bvalid;
    assign arready = !q.rvalid;
    assign ar_hs = arvalid && arready;
    assign wr_go = q.aw_ok && q.w_ok && !q.bvalid;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign rvalid = q.rvalid;
    assign rresp = q.rresp;
    assign rdata = q.rdata;
    assign alarm_match = q.match;
    assign adjust_done = q.adj_done;
    assign m = lane_mask(q.w_strb);
    assign tick = q.presc == TICK_LAST;
    assign sec_evt = tick && q.run && q.div == 8'hff;
    assign acc = {1'b0, q.sw_acc} + SW_STEP;

    always_comb
    begin
        d = q;
        d.rst_busy = 1'b0;
        d.adj_done = 1'b0;

        // ----------------------------------------------------------------
        // timebase, divider and busy window
        // ----------------------------------------------------------------
        d.presc = tick ? '0 : q.presc + 1'b1;
        if (q.busy)
        begin
            d.bcnt = q.bcnt + 1'b1;
            if (q.bcnt == TICK_LAST)
                d.busy = 1'b0;
        end
        if (tick && q.run)
            d.div = (q.div == 8'hff) ? {q.trim[6], q.trim} : q.div + 8'h01;
        // busy spans a full timebase step so software can always see it
        if (tick && q.trm_busy)
        begin
            d.trm_armed = 1'b1;
            if (q.trm_armed)
            begin
                d.trm_busy = 1'b0;
                d.trm_armed = 1'b0;
            end
        end

        // ----------------------------------------------------------------
        // time count-up, hold and corrections
        // ----------------------------------------------------------------
        if (sec_evt)
        begin
            if (q.hold)
                d.pend = 1'b1;
            else
            begin
                d.t = step_sec(q.t, q.f24);
                d.busy = 1'b1;
                d.bcnt = '0;
            end
        end
        else if (!q.hold && q.pend && q.run)
        begin
            d.t = step_sec(q.t, q.f24);
            d.pend = 1'b0;
            d.busy = 1'b1;
            d.bcnt = '0;
        end
        if (q.adj && !q.adj_run && tick)
        begin
            // forcing 59 makes the step clear seconds and carry a minute
            d.t.sec = 7'h00;
            if (q.t.sec >= 7'h30)
                d.t = step_sec('{pm: q.t.pm, hour: q.t.hour, min: q.t.min, sec: 7'h59},
                    q.f24);
            d.adj_run = 1'b1;
            d.busy = 1'b1;
            d.bcnt = '0;
        end
        else if (q.adj_run && !q.busy)
        begin
            d.adj = 1'b0;
            d.adj_run = 1'b0;
            d.adj_done = 1'b1;
        end

        // ----------------------------------------------------------------
        // stopwatch: run changes only land on a stopwatch clock
        // ----------------------------------------------------------------
        if (tick)
        begin
            d.sw_acc = acc[7:0];
            if (acc[8])
            begin
                d.sw_eff = q.sw_run;
                if (q.sw_eff)
                begin
                    d.sw_hund = (q.sw_hund >= 4'h9) ? 4'h0 : q.sw_hund + 4'h1;
                    if (q.sw_hund >= 4'h9)
                        d.sw_tenth = (q.sw_tenth >= 4'h9) ? 4'h0 : q.sw_tenth + 4'h1;
                end
            end
        end

        // ----------------------------------------------------------------
        // register writes
        // ----------------------------------------------------------------
        if (awvalid && awready)
        begin
            d.aw_ok = 1'b1;
            d.aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            d.w_ok = 1'b1;
            d.w_data = wdata[15:0];
            d.w_strb = wstrb[1:0];
        end
        if (q.bvalid && bready)
            d.bvalid = 1'b0;
        if (wr_go)
        begin
            d.aw_ok = 1'b0;
            d.w_ok = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = addr_ok(q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
            unique case (q.aw_addr)
                CTL_LOW_OFS:
                    if (q.w_strb[0])
                    begin
                        d.run = q.w_data[RUN_BIT];
                        d.f24 = q.w_data[FMT24_BIT];
                        d.hold = q.w_data[HOLD_BIT] && !q.trm_busy;
                        if (q.w_data[ADJ_BIT] && !q.adj)
                            d.adj = 1'b1;
                        if (q.w_data[SOFT_RST_BIT])
                        begin
                            d.div = 8'h00;
                            d.adj = 1'b0;
                            d.adj_run = 1'b0;
                            d.hold = 1'b0;
                            d.pend = 1'b0;
                            d.rst_busy = 1'b1;
                        end
                    end
                CTL_HIGH_OFS:
                    if (q.w_strb[0] && !q.trm_busy)
                    begin
                        d.trim = q.w_data[TRIM_LSB +: 7];
                        d.trm_busy = 1'b1;
                        d.trm_armed = 1'b0;
                    end
                ALARM_SEC_OFS:
                    if (q.w_strb[1])
                        d.alm.sec = q.w_data[SEC_LSB +: 7];
                ALARM_HM_OFS:
                begin
                    if (q.w_strb[0])
                        d.alm.min = q.w_data[MIN_LSB +: 7];
                    if (q.w_strb[1])
                    begin
                        d.alm.hour = q.w_data[HOUR_LSB +: 6];
                        d.alm.pm = q.w_data[PM_BIT];
                    end
                end
                SW_CTL_OFS:
                    if (q.w_strb[0])
                    begin
                        d.sw_run = q.w_data[SW_RUN_BIT];
                        if (q.w_data[SW_CLR_BIT])
                        begin
                            d.sw_hund = 4'h0;
                            d.sw_tenth = 4'h0;
                            d.sw_acc = 8'h00;
                        end
                    end
                SEC_DIV_OFS:
                    if (q.w_strb[1])
                        d.t.sec = q.w_data[SEC_LSB +: 7];
                HOUR_MIN_OFS:
                begin
                    if (q.w_strb[0])
                        d.t.min = q.w_data[MIN_LSB +: 7];
                    if (q.w_strb[1])
                    begin
                        d.t.hour = q.w_data[HOUR_LSB +: 6];
                        d.t.pm = q.w_data[PM_BIT] && !q.f24;
                    end
                end
                default: ;
            endcase
        end

        // ----------------------------------------------------------------
        // register reads
        // ----------------------------------------------------------------
        if (q.rvalid && rready)
            d.rvalid = 1'b0;
        if (ar_hs)
        begin
            d.rvalid = 1'b1;
            d.rresp = addr_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
            d.rdata = 32'h0000_0000;
            unique case (araddr)
                CTL_LOW_OFS:
                begin
                    d.rdata[RUN_BIT] = q.run;
                    d.rdata[SOFT_RST_BIT] = q.rst_busy;
                    d.rdata[ADJ_BIT] = q.adj;
                    d.rdata[FMT24_BIT] = q.f24;
                    d.rdata[HOLD_BIT] = q.hold;
                    d.rdata[BUSY_BIT] = q.busy;
                end
                CTL_HIGH_OFS: d.rdata[TRIM_BUSY_BIT] = q.trm_busy;
                ALARM_SEC_OFS: d.rdata[SEC_LSB +: 7] = q.alm.sec;
                ALARM_HM_OFS:
                    d.rdata[15:0] = {1'b0, q.alm.pm, q.alm.hour, 1'b0, q.alm.min};
                SW_CTL_OFS:
                begin
                    d.rdata[SW_TENTH_LSB +: 4] = q.sw_tenth;
                    d.rdata[SW_HUND_LSB +: 4] = q.sw_hund;
                    d.rdata[SW_RUN_BIT] = q.sw_run;
                end
                SEC_DIV_OFS:
                begin
                    d.rdata[SEC_LSB +: 7] = q.t.sec;
                    d.rdata[DIV_LSB +: 8] = q.div;
                end
                HOUR_MIN_OFS:
                    d.rdata[15:0] = {1'b0, q.t.pm && !q.f24, q.t.hour, 1'b0, q.t.min};
                default: ;
            endcase
        end

        // pm compared only in 12h mode
        d.match = q.t.sec == q.alm.sec && q.t.min == q.alm.min && q.t.hour == q.alm.hour
            && (q.f24 || q.t.pm == q.alm.pm);
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            q <= '0;
            q.t.hour <= HOUR_RST;
        end
        else
            q <= d;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    localparam int BUSY_LEN = TICK_DIV;
    logic [31:0] busy_len, adj_len, trm_len;
    logic wr_time;
    assign wr_time = wr_go && (q.aw_addr == SEC_DIV_OFS || q.aw_addr == HOUR_MIN_OFS);

    always_ff @(posedge clk)
    begin
        if (rst || !q.busy)
            busy_len <= 32'h0;
        else
            busy_len <= busy_len + 32'h1;
        if (rst || !q.adj)
            adj_len <= 32'h0;
        else
            adj_len <= adj_len + 32'h1;
        if (rst || !q.trm_busy)
            trm_len <= 32'h0;
        else
            trm_len <= trm_len + 32'h1;
    end

    sequence pend_released;
        !q.hold && q.pend && q.run && !sec_evt;
    endsequence

    sequence one_step_taken;
        q.busy && !q.pend;
    endsequence

    hold_busy_lock_a: assert property ((q.trm_busy && !q.hold) |=> !q.hold)
        else $error("hold set while regulation busy");
    hold_freeze_a: assert property ((q.hold && !wr_time && !(q.adj && tick)) |=> $stable(q.t.sec))
        else $error("seconds moved while held");
    busy_window_a: assert property ($fell(q.busy) |-> busy_len == BUSY_LEN)
        else $error("busy window length wrong");
    adjust_bound_a: assert property (adj_len <= 2 * TICK_DIV + 2)
        else $error("adjust took too long");
    plus_one_a: assert property (pend_released |=> one_step_taken)
        else $error("held count-up not applied once");
    soft_reset_a: assert property (q.rst_busy |-> (q.div == 8'h00 && !q.adj && !q.hold))
        else $error("soft reset left state");
    trim_busy_a: assert property ((wr_go && q.aw_addr == CTL_HIGH_OFS && q.w_strb[0]
        && !q.trm_busy) |=> q.trm_busy)
        else $error("trim write did not set busy");
    trim_done_a: assert property (trm_len <= 2 * TICK_DIV)
        else $error("regulation busy stuck");
    pm_read_a: assert property ((ar_hs && araddr == HOUR_MIN_OFS && q.f24)
        |=> !q.rdata[PM_BIT])
        else $error("pm visible in 24h mode");
    sw_clear_a: assert property ((wr_go && q.aw_addr == SW_CTL_OFS && q.w_strb[0]
        && q.w_data[SW_CLR_BIT]) |=> (q.sw_hund == 4'h0 && q.sw_tenth == 4'h0))
        else $error("stopwatch not cleared");
    sec_range_a: assert property ($rose(q.busy) |-> (q.t.sec <= 7'h59
        && q.t.sec[3:0] <= 4'h9))
        else $error("seconds out of range after step");

endmodule

// File: rtc_pkg.sv
// shared constants and state types for the calendar clock control block
package rtc_pkg;

    localparam int CLK_HZ = 40_000_000;
    // busy window and timebase step: 1/256 second
    localparam int TIMEBASE_DEN = 256;
    localparam int TICK_CYCLES = CLK_HZ / TIMEBASE_DEN;
    // 30-second correction completes within 2/256 second
    localparam int ADJ_TIME_NUM = 2;
    localparam int ADJ_MAX_CYCLES = (CLK_HZ * ADJ_TIME_NUM) / TIMEBASE_DEN;
    localparam int PRESC_W = 24;

    // register byte offsets
    localparam logic [7:0] CTL_LOW_OFS = 8'h00;
    localparam logic [7:0] CTL_HIGH_OFS = 8'h04;
    localparam logic [7:0] ALARM_SEC_OFS = 8'h08;
    localparam logic [7:0] ALARM_HM_OFS = 8'h0c;
    localparam logic [7:0] SW_CTL_OFS = 8'h10;
    localparam logic [7:0] SEC_DIV_OFS = 8'h14;
    localparam logic [7:0] HOUR_MIN_OFS = 8'h18;

    // control low byte
    localparam int RUN_BIT = 0;
    localparam int SOFT_RST_BIT = 1;
    localparam int ADJ_BIT = 2;
    localparam int FMT24_BIT = 4;
    localparam int HOLD_BIT = 5;
    localparam int BUSY_BIT = 6;
    // control high byte
    localparam int TRIM_LSB = 0;
    localparam int TRIM_BUSY_BIT = 7;
    // alarm and counter fields
    localparam int SEC_LSB = 8;
    localparam int MIN_LSB = 0;
    localparam int HOUR_LSB = 8;
    localparam int PM_BIT = 14;
    localparam int DIV_LSB = 0;
    // stopwatch fields
    localparam int SW_RUN_BIT = 0;
    localparam int SW_CLR_BIT = 4;
    localparam int SW_HUND_LSB = 8;
    localparam int SW_TENTH_LSB = 12;
    // stopwatch phase step per timebase tick (about 100 steps per 256 ticks)
    localparam logic [8:0] SW_STEP = 9'h064;

    localparam logic [5:0] HOUR_RST = 6'h12;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic pm;
        logic [5:0] hour;
        logic [6:0] min;
        logic [6:0] sec;
    } time_t;

    typedef struct packed {
        logic aw_ok;
        logic w_ok;
        logic [7:0] aw_addr;
        logic [15:0] w_data;
        logic [1:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [PRESC_W-1:0] presc;
        logic [PRESC_W-1:0] bcnt;
        logic [7:0] div;
        logic run;
        logic rst_busy;
        logic adj;
        logic adj_run;
        logic adj_done;
        logic f24;
        logic hold;
        logic pend;
        logic busy;
        logic trm_busy;
        logic trm_armed;
        logic [6:0] trim;
        time_t t;
        time_t alm;
        logic sw_run;
        logic sw_eff;
        logic [7:0] sw_acc;
        logic [3:0] sw_hund;
        logic [3:0] sw_tenth;
        logic match;
    } st_t;

endpackage

// File: rtc_calendar_stopwatch_control_bench.sv
// self-checking bench for the calendar clock control block
`timescale 1ns/1ps
module rtc_calendar_stopwatch_control_bench import rtc_pkg::*;;
    // ------
    // stimulus and design
    // ------
    localparam int TD = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, alarm_match, adjust_done;
    logic [1:0] bresp, rresp, rd_rsp, wr_rsp;
    logic [31:0] rdata, rd_val;
    int num_errors = 0;
    int n_checks = 0;
    int n_adj = 0;

    always #12.5 clk = ~clk;
    always @(posedge clk) if (adjust_done === 1'b1) n_adj <= n_adj + 1;

    // response readies stay high: the bench is always willing to take an answer
    rtc_calendar_stopwatch_control #(.TICK_DIV(TD)) i_dut (.clk(clk), .rst(rst),
        .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arprot(3'h0),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(1'b1), .alarm_match(alarm_match),
        .adjust_done(adjust_done));

    // ------
    // bus and checking tasks
    // ------
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic hang();
        num_errors++;
        $display("Error at %0t: bus answer never came", $time);
        wrap_up();
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // readies are judged at the falling edge; they only move after a rising one
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic ha, hw, hb;
        int n;
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= 4'h3;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 64; n++)
        begin
            @(negedge clk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid;
            wr_rsp = bresp;
            @(posedge clk);
            if (ha)
                awvalid <= 1'b0;
            if (hw)
                wvalid <= 1'b0;
            if (hb)
                break;
        end
        if (n == 64)
            hang();
    endtask

    task automatic rd(input logic [7:0] a);
        logic ha, hr;
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 64; n++)
        begin
            @(negedge clk);
            ha = arvalid && arready;
            hr = rvalid;
            rd_val = rdata;
            rd_rsp = rresp;
            @(posedge clk);
            if (ha)
                arvalid <= 1'b0;
            if (hr)
                break;
        end
        if (n == 64)
            hang();
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk(rd_val, exp);
    endtask

    // ------
    // scenarios
    // ------
    task automatic t_reset();
        rc(CTL_LOW_OFS, 32'h0);
        rc(CTL_HIGH_OFS, 32'h0);
        rc(ALARM_SEC_OFS, 32'h0);
        rc(ALARM_HM_OFS, 32'h0);
        rc(SW_CTL_OFS, 32'h0);
        rc(SEC_DIV_OFS, 32'h0);
        rc(HOUR_MIN_OFS, 32'h1200);
        chk({30'h0, rd_rsp}, {30'h0, RESP_OKAY});
        rc(8'h1c, 32'h0);
        chk({30'h0, rd_rsp}, {30'h0, RESP_SLVERR});
        wr(8'h1c, 16'hffff);
        chk({30'h0, wr_rsp}, {30'h0, RESP_SLVERR});
    endtask

    task automatic t_trim();
        logic [6:0] v[2] = '{7'h05, 7'h00};
        for (int i = 0; i < 2; i++)
        begin
            wr(CTL_HIGH_OFS, {9'h000, v[i]});
            rc(CTL_HIGH_OFS, 32'h80);
            wr(CTL_LOW_OFS, 16'h0020);
            rc(CTL_LOW_OFS, 32'h0);
            idle(2 * TD);
            rc(CTL_HIGH_OFS, 32'h0);
        end
    endtask

    task automatic t_format();
        wr(HOUR_MIN_OFS, 16'h4111);
        chk({30'h0, wr_rsp}, {30'h0, RESP_OKAY});
        rc(HOUR_MIN_OFS, 32'h4111);
        wr(HOUR_MIN_OFS, 16'h0111);
        wr(CTL_LOW_OFS, 16'h0010);
        rc(HOUR_MIN_OFS, 32'h0111);
        wr(HOUR_MIN_OFS, 16'h4111);
        rc(HOUR_MIN_OFS, 32'h0111);
        wr(HOUR_MIN_OFS, 16'h2359);
        rc(HOUR_MIN_OFS, 32'h2359);
        wr(ALARM_SEC_OFS, 16'hffff);
        rc(ALARM_SEC_OFS, 32'h7f00);
        wr(ALARM_HM_OFS, 16'h5259);
        rc(ALARM_HM_OFS, 32'h5259);
    endtask

    // clock stopped, 24h mode: seconds 35 carry a minute, seconds 20 do not
    task automatic t_adjust();
        logic [15:0] s[2] = '{16'h3500, 16'h2000};
        logic [31:0] m[2] = '{32'h0111, 32'h0110};
        int k;
        for (int i = 0; i < 2; i++)
        begin
            k = n_adj;
            wr(SEC_DIV_OFS, s[i]);
            wr(HOUR_MIN_OFS, 16'h0110);
            wr(CTL_LOW_OFS, 16'h0014);
            rd(CTL_LOW_OFS);
            chk(rd_val & 32'h4, 32'h4);
            idle(2 * TD + 4);
            rc(CTL_LOW_OFS, 32'h10);
            rd(SEC_DIV_OFS);
            chk(rd_val & 32'h7f00, 32'h0);
            rc(HOUR_MIN_OFS, m[i]);
            chk(n_adj - k, 32'h1);
        end
        wr(ALARM_SEC_OFS, 16'h0000);
        wr(ALARM_HM_OFS, 16'h4110);
        idle(3);
        chk({31'h0, alarm_match}, 32'h1);
        wr(CTL_LOW_OFS, 16'h0000);
        idle(3);
        chk({31'h0, alarm_match}, 32'h0);
    endtask

    task automatic t_run();
        logic [31:0] s;
        wr(SEC_DIV_OFS, 16'h0000);
        wr(CTL_LOW_OFS, 16'h0011);
        idle(256 * TD + 60);
        rd(SEC_DIV_OFS);
        chk(rd_val & 32'h7f00, 32'h0100);
        wr(CTL_LOW_OFS, 16'h0031);
        idle(512 * TD);
        rd(SEC_DIV_OFS);
        chk(rd_val & 32'h7f00, 32'h0100);
        wr(CTL_LOW_OFS, 16'h0011);
        idle(4);
        rd(SEC_DIV_OFS);
        chk(rd_val & 32'h7f00, 32'h0200);
        wr(CTL_LOW_OFS, 16'h0010);
        rd(SEC_DIV_OFS);
        s = rd_val;
        idle(300 * TD);
        rc(SEC_DIV_OFS, s);
        wr(CTL_LOW_OFS, 16'h0030);
        rc(CTL_LOW_OFS, 32'h30);
        wr(CTL_LOW_OFS, 16'h0012);
        rc(CTL_LOW_OFS, 32'h10);
        rd(SEC_DIV_OFS);
        chk(rd_val & 32'hff, 32'h0);
    endtask

    task automatic t_stopwatch();
        logic [31:0] a;
        wr(SW_CTL_OFS, 16'h0001);
        idle(200 * TD);
        wr(SW_CTL_OFS, 16'h0000);
        idle(4 * TD);
        rd(SW_CTL_OFS);
        a = rd_val;
        chk({31'h0, a[15:8] != 8'h00}, 32'h1);
        idle(100 * TD);
        rc(SW_CTL_OFS, a);
        wr(SW_CTL_OFS, 16'h0010);
        rc(SW_CTL_OFS, 32'h0);
        wr(SW_CTL_OFS, 16'h0001);
        idle(30 * TD);
        wr(SW_CTL_OFS, 16'h0011);
        rd(SW_CTL_OFS);
        chk(rd_val & 32'hf0ff, 32'h1);
        idle(30 * TD);
        rd(SW_CTL_OFS);
        chk({31'h0, rd_val[15:8] != 8'h00}, 32'h1);
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_trim();
        t_format();
        t_adjust();
        t_run();
        t_stopwatch();
        wrap_up();
    end
endmodule
